// ==== pic_defines.svh ====
// Port addresses, field positions and reset values of the interrupt controller front end
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

// ********************************************************
// Port addresses
// ********************************************************
`define PIC_PORT_EVEN 8'h20
`define PIC_PORT_ODD 8'h21

// ********************************************************
// First initialization word fields
// ********************************************************
`define PIC_W1_START_BIT 4
`define PIC_W1_LEVEL_BIT 3
`define PIC_W1_SINGLE_BIT 1

// ********************************************************
// Vector base field and widths
// ********************************************************
`define PIC_VB_MSB 7
`define PIC_VB_LSB 3
`define PIC_NUM_INPUTS 8

// ********************************************************
// Reset values
// ********************************************************
`define PIC_VB_RST 5'h00
`define PIC_MAP_RST 8'h00
`define PIC_LEVEL_RST 1'b0
`define PIC_SINGLE_RST 1'b1

`endif

// ==== pic_pkg.sv ====
// Types shared by the interrupt controller front end
package pic_pkg;
   // ********************************************************
   // Initialization sequence position
   // ********************************************************
   typedef enum logic [1:0] {
      PIC_SEQ_IDLE,
      PIC_SEQ_VB,
      PIC_SEQ_MAP,
      PIC_SEQ_RUN
   } pic_seq_t;

   typedef logic [7:0] pic_byte_t;
   typedef logic [2:0] pic_idx_t;
endpackage : pic_pkg

// ==== pic_req_if.sv ====
// Carrier between the controller core and the request detector
`timescale 1ns/1ps
interface pic_req_if;
   logic levelMode;
   logic flush;
   logic [7:0] reqIn;
   logic [7:0] clearOne;
   logic [7:0] pending;

   modport det (
      input levelMode,
      input flush,
      input reqIn,
      input clearOne,
      output pending
   );
   modport ctl (
      output levelMode,
      output flush,
      output reqIn,
      output clearOne,
      input pending
   );
endinterface : pic_req_if

// ==== pic_req_detect.sv ====
// Per-input request detector: edge or level sensing with a pending latch
`timescale 1ns/1ps
module pic_req_detect
   import pic_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   pic_req_if.det rq
);
   // ********************************************************
   // One detector per request input
   // ********************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_in
         logic prev_r;
         logic prev_nxt;
         logic pend_r;
         logic pend_nxt;

         // Edge mode keeps the latch until acknowledged; a new edge beats the clear
         always_comb begin
            prev_nxt = rq.reqIn[gi];
            if (rq.flush) begin
               pend_nxt = 1'b0;
            end else if (rq.levelMode) begin
               pend_nxt = rq.reqIn[gi];
            end else begin
               pend_nxt = (pend_r & ~rq.clearOne[gi]) | (rq.reqIn[gi] & ~prev_r);
            end
         end

         always_ff @(posedge clk) begin
            if (srst) begin
               prev_r <= 1'b0;
               pend_r <= 1'b0;
            end else begin
               prev_r <= prev_nxt;
               pend_r <= pend_nxt;
            end
         end

         assign rq.pending[gi] = pend_r;

         a_edge_sets: assert property (@(posedge clk) disable iff (srst)
            !rq.levelMode && !rq.flush && rq.reqIn[gi] && !prev_r |=> pend_r)
            else $error("rising request edge not latched");
         a_level_follows: assert property (@(posedge clk) disable iff (srst)
            rq.levelMode && !rq.flush |=> pend_r == $past(rq.reqIn[gi]))
            else $error("level request not followed");
      end
   endgenerate
endmodule : pic_req_detect

// ==== pic_init_top.sv ====
// Initialization front end of an eight-input cascadable interrupt controller
`timescale 1ns/1ps
`include "pic_defines.svh"
module pic_init_top
   import pic_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ioWrStb,
   input wire logic [7:0] ioAddr,
   input wire logic [7:0] ioWrData,
   input wire logic [7:0] reqIn,
   input wire logic intAck,
   output logic intReq,
   output logic [7:0] vecData,
   output logic vecValid,
   output logic slaveVecEn,
   output logic [2:0] cascadeId,
   output logic initDone,
   output logic levelMode,
   output logic singleMode,
   output logic [7:0] slaveMap
);
   // Every check in this module samples on the rising edge and sleeps in reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // ********************************************************
   // Write decode
   // ********************************************************
   logic wrEven;
   logic wrOdd;
   logic startWr;

   assign wrEven = ioWrStb && (ioAddr == `PIC_PORT_EVEN);
   assign wrOdd = ioWrStb && (ioAddr == `PIC_PORT_ODD);
   // Other addresses fall through untouched; the registers that share the bus
   // decode their own ports, so no write here is ever answered on the bus
   // Bit 4 alone tells an initialization word from a command word
   assign startWr = wrEven && ioWrData[`PIC_W1_START_BIT];

   // ********************************************************
   // Initialization sequence and configuration
   // ********************************************************
   pic_seq_t seq_r;
   pic_seq_t seq_nxt;
   logic level_r;
   logic level_nxt;
   logic single_r;
   logic single_nxt;
   logic [4:0] vecBase_r;
   logic [4:0] vecBase_nxt;
   logic [7:0] map_r;
   logic [7:0] map_nxt;

   // Idle until a start write, then the vector base, then the slave map in
   // cascade mode only; a start write at any point begins again from the top,
   // which is how software recovers from a half-written sequence
   // Sequence position decides which word an odd write lands in
   always_comb begin
      seq_nxt = seq_r;
      level_nxt = level_r;
      single_nxt = single_r;
      vecBase_nxt = vecBase_r;
      map_nxt = map_r;
      if (startWr) begin
         seq_nxt = PIC_SEQ_VB;
         level_nxt = ioWrData[`PIC_W1_LEVEL_BIT];
         single_nxt = ioWrData[`PIC_W1_SINGLE_BIT];
      end else if (wrOdd) begin
         unique case (seq_r)
            PIC_SEQ_VB: begin
               vecBase_nxt = ioWrData[`PIC_VB_MSB:`PIC_VB_LSB];
               // Single mode has no slave map, so the third word is skipped
               seq_nxt = single_r ? PIC_SEQ_RUN : PIC_SEQ_MAP;
            end
            PIC_SEQ_MAP: begin
               map_nxt = ioWrData;
               seq_nxt = PIC_SEQ_RUN;
            end
            PIC_SEQ_IDLE, PIC_SEQ_RUN: begin
               // Mask and command words live in another block
               seq_nxt = seq_r;
            end
         endcase
      end
   end

   // Configuration holds until reset, the next start write, or an odd write in the sequence
   always_ff @(posedge clk) begin
      if (srst) begin
         seq_r <= PIC_SEQ_IDLE;
         level_r <= `PIC_LEVEL_RST;
         single_r <= `PIC_SINGLE_RST;
         vecBase_r <= `PIC_VB_RST;
         map_r <= `PIC_MAP_RST;
      end else begin
         seq_r <= seq_nxt;
         level_r <= level_nxt;
         single_r <= single_nxt;
         vecBase_r <= vecBase_nxt;
         map_r <= map_nxt;
      end
   end

   // Mode and map outputs come straight from the configuration flip-flops; initDone decodes the sequence position
   assign initDone = (seq_r == PIC_SEQ_RUN);
   assign levelMode = level_r;
   assign singleMode = single_r;
   assign slaveMap = map_r;

   // ********************************************************
   // Request detection
   // ********************************************************
   // The detector keeps one latch per input; this side only feeds it
   pic_req_if rq ();
   logic [7:0] clear_c;

   assign rq.levelMode = level_r;
   // Restarting initialization forgets stale edges
   assign rq.flush = startWr;
   assign rq.reqIn = reqIn;
   assign rq.clearOne = clear_c;
   // Level mode ignores the clear: a held input asks again at once, the price
   // of not needing a fresh edge after every acknowledge

   pic_req_detect u_detect (
      .clk(clk),
      .srst(srst),
      .rq(rq.det)
   );

   // ********************************************************
   // Priority resolver, input 0 highest
   // ********************************************************
   logic [2:0] winIdx;
   logic anyPend;

   // Counting down lets the lowest pending index overwrite the others; the
   // order is fixed, since masking and rotation belong to the command words
   always_comb begin
      winIdx = 3'h0;
      anyPend = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         if (rq.pending[i]) begin
            winIdx = 3'(i);
            anyPend = 1'b1;
         end
      end
   end

   // Requests are withheld until the sequence has finished
   assign intReq = anyPend && initDone;

   // ********************************************************
   // Acknowledge and vector delivery
   // ********************************************************
   logic ackTake;
   logic slaveWins;
   logic [7:0] vec_r;
   logic [7:0] vec_nxt;
   logic vecValid_r;
   logic vecValid_nxt;
   logic slaveEn_r;
   logic slaveEn_nxt;
   logic [2:0] casc_r;
   logic [2:0] casc_nxt;

   // An acknowledge with no request up is dropped; the host would otherwise
   // read a vector that names nothing
   assign ackTake = intAck && intReq;
   // Slave only steps in when cascade mode and the map both say so
   assign slaveWins = !single_r && map_r[winIdx];
   assign clear_c = ackTake ? (8'h01 << winIdx) : 8'h00;

   // Vector and slave-select pulses last one cycle after the acknowledge
   always_comb begin
      vec_nxt = vec_r;
      vecValid_nxt = 1'b0;
      slaveEn_nxt = 1'b0;
      casc_nxt = casc_r;
      if (ackTake) begin
         casc_nxt = winIdx;
         if (slaveWins) begin
            slaveEn_nxt = 1'b1;
         end else begin
            vec_nxt = {vecBase_r, winIdx};
            vecValid_nxt = 1'b1;
         end
      end
   end

   // Pulses clear by themselves after one cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         vec_r <= 8'h00;
         vecValid_r <= 1'b0;
         slaveEn_r <= 1'b0;
         casc_r <= 3'h0;
      end else begin
         vec_r <= vec_nxt;
         vecValid_r <= vecValid_nxt;
         slaveEn_r <= slaveEn_nxt;
         casc_r <= casc_nxt;
      end
   end

   // Cascade index holds until the next acknowledge, vector byte until the next own-vector acknowledge
   assign vecData = vec_r;
   assign vecValid = vecValid_r;
   assign slaveVecEn = slaveEn_r;
   assign cascadeId = casc_r;

   // ********************************************************
   // Checks
   // ********************************************************
   // Start write: begins the sequence, takes both modes and forgets old
   // requests; a command write with bit 4 clear must leave all of it alone
   a_init_start: assert property (startWr |=> seq_r == PIC_SEQ_VB)
      else $error("start write did not begin sequence");
   a_no_start: assert property (wrEven && !ioWrData[4] && initDone |=> initDone)
      else $error("write without start bit restarted sequence");
   a_start_flush: assert property (startWr |=> rq.pending == 8'h00)
      else $error("start write left stale requests pending");
   a_trigger_mode: assert property (startWr |=> level_r == $past(ioWrData[3]))
      else $error("trigger mode not taken from first word");
   a_cascade_sel: assert property (startWr |=> single_r == $past(ioWrData[1]))
      else $error("single or cascade mode not taken from first word");
   a_mode_hold: assert property (!startWr
      |=> level_r == $past(level_r) && single_r == $past(single_r))
      else $error("trigger or cascade mode changed without start write");

   // Odd writes walk the sequence one word at a time; outside it they belong
   // to the mask and command words and must change nothing here
   a_single_skip: assert property (!startWr && wrOdd && seq_r == PIC_SEQ_VB && single_r
      |=> seq_r == PIC_SEQ_RUN && map_r == $past(map_r))
      else $error("single mode did not skip slave map");
   a_base_load: assert property (!startWr && wrOdd && seq_r == PIC_SEQ_VB
      |=> vecBase_r == $past(ioWrData[7:3]) ##1 vecBase_r == $past(vecBase_r)
         || $past(startWr) || $past(wrOdd))
      else $error("vector base not loaded");
   a_map_load: assert property (!startWr && wrOdd && seq_r == PIC_SEQ_MAP
      |=> map_r == $past(ioWrData) && seq_r == PIC_SEQ_RUN)
      else $error("slave map not loaded");
   a_casc_step: assert property (startWr && !ioWrData[1] ##1 !startWr && wrOdd
      |=> seq_r == PIC_SEQ_MAP)
      else $error("cascade sequence did not await slave map");
   a_idle_odd: assert property (!startWr && wrOdd && seq_r == PIC_SEQ_IDLE
      |=> seq_r == PIC_SEQ_IDLE)
      else $error("odd write before first word moved sequence");
   a_run_hold: assert property (!startWr && initDone
      |=> initDone && vecBase_r == $past(vecBase_r) && map_r == $past(map_r))
      else $error("configuration changed after sequence end");

   // Resolver: the winner is pending and nothing below it is
   a_win_pending: assert property (anyPend |-> rq.pending[winIdx])
      else $error("winning input is not pending");
   a_win_lowest: assert property (anyPend
      |-> (rq.pending & ((8'h01 << winIdx) - 8'h01)) == 8'h00)
      else $error("a lower pending input was passed over");
   a_edge_clear: assert property (ackTake && !level_r && !startWr && $stable(reqIn)
      |=> !rq.pending[$past(winIdx)])
      else $error("acknowledged edge request still pending");
   a_level_held: assert property (ackTake && level_r && !startWr && reqIn[winIdx]
      |=> rq.pending[$past(winIdx)])
      else $error("held level request dropped by acknowledge");
   a_no_early_req: assert property (!initDone |-> !intReq)
      else $error("request raised before initialization");

   // Acknowledge: exactly one supplier of the vector, and only when asked
   a_vec_low: assert property (ackTake && !slaveWins
      |=> vecValid_r && vec_r[2:0] == $past(winIdx) && vec_r[7:3] == $past(vecBase_r))
      else $error("vector does not name winning input");
   a_slave_vec: assert property (ackTake && slaveWins
      |=> slaveEn_r && !vecValid_r && casc_r == $past(winIdx))
      else $error("slave not given the vector");
   a_one_source: assert property (!(vecValid_r && slaveEn_r))
      else $error("own and slave vector offered together");
   a_ack_refused: assert property (intAck && !intReq |=> !vecValid_r && !slaveEn_r)
      else $error("acknowledge without request answered");
   a_vec_hold: assert property (!ackTake
      |=> vec_r == $past(vec_r) && casc_r == $past(casc_r))
      else $error("vector changed without acknowledge");
   a_single_own: assert property (single_r |-> !slaveEn_nxt)
      else $error("single mode handed vector to slave");

   // Main scenarios: both sequence lengths and both vector suppliers,
   // with level triggering seen at an acknowledge as well
   c_single_init: cover property (startWr && ioWrData[1] ##1 wrOdd ##[1:20] initDone);
   c_cascade_init: cover property (startWr && !ioWrData[1] ##[1:20] wrOdd && seq_r == PIC_SEQ_MAP);
   c_own_vector: cover property (ackTake && !slaveWins ##1 vecValid_r);
   c_slave_vector: cover property (ackTake && slaveWins && winIdx == 3'h2);
   c_level_ack: cover property (ackTake && level_r);
endmodule : pic_init_top

// ==== pic_slave_model.sv ====
// Behavioural slave controller answering the master's cascade hand-off
`timescale 1ns/1ps
module pic_slave_model
   import pic_pkg::*;
#(
   parameter logic [4:0] SLV_BASE = 5'h0e,
   parameter logic [2:0] SLV_IRQ = 3'h5
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic slaveVecEn,
   output pic_byte_t slvVec,
   output logic slvValid
);
   // ****
   // Vector answer
   // ****
   // Set up for cascade, so it answers every hand-off; off the bus the byte
   // flips each cycle so a stale sample never passes for an answer
   always_ff @(posedge clk) begin
      if (srst) begin
         slvVec <= 8'h00;
         slvValid <= 1'b0;
      end else begin
         slvValid <= slaveVecEn;
         slvVec <= slaveVecEn ? {SLV_BASE, SLV_IRQ} : ~slvVec;
      end
   end
endmodule : pic_slave_model

// ==== interrupt_controller_init_tb_top.sv ====
// Self-checking testbench of the interrupt controller front end
`timescale 1ns/1ps
module interrupt_controller_init_tb_top
   import pic_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic ioWrStb = 1'b0;
   logic [7:0] ioAddr = 8'h00;
   logic [7:0] ioWrData = 8'h00;
   logic [7:0] reqIn = 8'h00;
   logic intAck = 1'b0;
   logic intReq, vecValid, slaveVecEn, initDone, levelMode, singleMode, slvValid;
   logic [7:0] vecData, slaveMap, slvVec, base, mask;
   logic [2:0] cascadeId, w;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int seed = 32'h4bf9;

   always #50 clk = ~clk;

   pic_init_top dut (.clk(clk), .srst(srst), .ioWrStb(ioWrStb), .ioAddr(ioAddr),
      .ioWrData(ioWrData), .reqIn(reqIn), .intAck(intAck), .intReq(intReq),
      .vecData(vecData), .vecValid(vecValid), .slaveVecEn(slaveVecEn),
      .cascadeId(cascadeId), .initDone(initDone), .levelMode(levelMode),
      .singleMode(singleMode), .slaveMap(slaveMap));
   pic_slave_model slave (.clk(clk), .srst(srst), .slaveVecEn(slaveVecEn),
      .slvVec(slvVec), .slvValid(slvValid));

   // ****
   // Shared tasks
   // ****
   task automatic close_out;
      if (err_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One write, then an idle cycle so the strobe is never set twice at one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      ioWrStb <= 1'b1;
      ioAddr <= a;
      ioWrData <= d;
      @(posedge clk);
      ioWrStb <= 1'b0;
      @(posedge clk);
   endtask : wr

   // Words go back to back with the strobe held up, as the host may do
   task automatic init(input logic [7:0] w1, input logic [7:0] vb, input logic [7:0] map);
      ioWrStb <= 1'b1;
      ioAddr <= 8'h20;
      ioWrData <= w1;
      @(posedge clk);
      ioAddr <= 8'h21;
      ioWrData <= vb;
      if (!w1[1]) begin
         @(posedge clk);
         ioWrData <= map;
      end
      @(posedge clk);
      ioWrStb <= 1'b0;
      @(posedge clk);
      #1;
   endtask : init

   // Waits for a request, acknowledges it and checks who supplies the vector
   task automatic ack_chk(input logic own, input logic [7:0] ev, input logic [2:0] id,
         input logic after);
      int n;
      n = 0;
      #1;
      while (intReq !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("intReq", 8'h01, {7'h00, intReq});
      @(posedge clk);
      intAck <= 1'b1;
      @(posedge clk);
      intAck <= 1'b0;
      #1;
      chk("vecValid", {7'h00, own}, {7'h00, vecValid});
      chk("slaveVecEn", {7'h00, !own}, {7'h00, slaveVecEn});
      chk("cascadeId", {5'h00, id}, {5'h00, cascadeId});
      chk("vecData", ev, vecData);
      chk("intReq after", {7'h00, after}, {7'h00, intReq});
      @(posedge clk);
   endtask : ack_chk

   function automatic logic [2:0] lowest(input logic [7:0] m);
      for (int i = 7; i >= 0; i--) begin
         if (m[i]) lowest = 3'(i);
      end
   endfunction : lowest

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         close_out();
      end
   end

   // ****
   // Main sequence
   // ****
   initial begin
      repeat (3) @(posedge clk);
      #1;
      chk("reset mode", 8'h02, {6'h00, singleMode, levelMode});
      chk("reset map", 8'h00, slaveMap);
      @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      // Acknowledge and odd write before any first word are both ignored
      intAck <= 1'b1;
      wr(8'h21, 8'h5a);
      intAck <= 1'b0;
      #1;
      chk("stray ack", 8'h00, {6'h00, vecValid, slaveVecEn});
      @(posedge clk);
      // Even write without the start bit leaves the sequence idle
      wr(8'h20, 8'h0a);
      #1;
      chk("no start", 8'h00, {6'h00, initDone, levelMode});
      // Random single-mode runs, edge and level in turn
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         base = 8'($random(seed));
         mask = 8'($random(seed)) | (8'h01 << i);
         w = lowest(mask);
         init(8'h12 | {4'h0, i[0], 3'h0}, base, 8'h00);
         chk("mode", {5'h00, 1'b1, i[0], 1'b1}, {5'h00, singleMode, levelMode, initDone});
         @(posedge clk);
         reqIn <= mask;
         ack_chk(1'b1, {base[7:3], w}, w, i[0] || ((mask & ~(8'h01 << w)) != 0));
         reqIn <= 8'h00;
      end
      // Cascade with a slave on input 2, then a stray odd write
      init(8'h10, 8'h40, 8'h04);
      chk("cascade", 8'h01, {6'h00, singleMode, initDone});
      @(posedge clk);
      wr(8'h21, 8'hff);
      #1;
      chk("slaveMap", 8'h04, slaveMap);
      // Command write with bit 4 clear after the sequence restarts nothing
      @(posedge clk);
      wr(8'h20, 8'h0a);
      #1;
      chk("no restart", 8'h02, {6'h00, initDone, levelMode});
      @(posedge clk);
      reqIn <= 8'h0c;
      // Own vector byte still holds the last single-mode answer
      ack_chk(1'b0, {base[7:3], w}, 3'h2, 1'b1);
      #1;
      chk("slave vector", 8'h01, {7'h00, slvValid});
      chk("slave byte", 8'h75, slvVec);
      ack_chk(1'b1, 8'h43, 3'h3, 1'b0);
      close_out();
   end
endmodule : interrupt_controller_init_tb_top
